// ===== src/pps_pkg.sv
// Contract
// - The upper three bits of each selector pick the port: 000 A, 001 B, 010 C, 011 D, 100 E, 101 F.
// - The lower three bits of each selector pick the pin 0 to 7 within the chosen port.
// - Power-on and brown-out reset load each selector's default location; other resets keep it.
// - Bits 7 and 6 of each selector ignore writes and read as zero.
package pps_pkg;
  localparam int PPS_NUM_PORTS = 6;
  localparam int PPS_SEL_W = 6;
  localparam int PPS_PORT_LSB = 3;
  localparam int PPS_PIN_LSB = 0;
  localparam int PPS_FIELD_W = 3;
  localparam logic [11:0] PPS_SEL_BASE = 12'h000;
  localparam logic [11:0] PPS_STATUS_ADDR = 12'hF00;
  localparam logic [7:0] PPS_IMPL_MASK = 8'h3F;
  localparam logic [1:0] PPS_HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] PPS_RESP_OKAY = 32'h0000_0000;
  localparam logic [5:0] PPS_DEFAULT_SEL = 6'h00;
  // Port code in bits 5:3, pin in bits 2:0
  function automatic logic [2:0] pps_port_of(input logic [5:0] sel);
    return sel[PPS_PORT_LSB +: PPS_FIELD_W];
  endfunction
  function automatic logic [2:0] pps_pin_of(input logic [5:0] sel);
    return sel[PPS_PIN_LSB +: PPS_FIELD_W];
  endfunction
endpackage

// ===== src/pps_route.sv
`timescale 1ns/10ps
module pps_route
  import pps_pkg::*;
(
  input wire logic [5:0] sel_in, // Port and pin code
  input wire logic [8*PPS_NUM_PORTS-1:0] pins_in, // All port pins, port A lowest
  output logic level_out // Routed pin level
);
  logic [2:0] port_code;
  logic [2:0] pin_code;
  always_comb begin
    port_code = pps_port_of(sel_in);
    pin_code = pps_pin_of(sel_in);
    // Reserved port codes read as low rather than aliasing a real port
    if (int'(port_code) < PPS_NUM_PORTS) begin
      level_out = pins_in[{port_code, pin_code}];
    end else begin
      level_out = 1'b0;
    end
  end
endmodule

// ===== src/pps_top.sv
`timescale 1ns/10ps
module pps_top
  import pps_pkg::*;
#(
  parameter int N_INPUTS = 4,
  parameter logic [6*N_INPUTS-1:0] DEFAULTS = '0
)(
  input wire logic clock_in, // 25 MHz clock
  input wire logic rstn_in, // Bus reset, other causes, active low
  input wire logic por_rstn_in, // Power-on or brown-out reset, active low
  input wire logic hsel, // AHB select
  input wire logic [11:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response
  input wire logic [8*PPS_NUM_PORTS-1:0] pins_in, // Port pins A..F
  output logic [N_INPUTS-1:0] periph_out // Routed peripheral inputs
);
  typedef struct packed {
    logic [N_INPUTS-1:0][5:0] sel;
  } pps_sel_t;
  typedef struct packed {
    logic wr_pend;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic [N_INPUTS-1:0] route;
  } pps_bus_t;

  pps_sel_t sel_q, sel_d;
  pps_bus_t bus_q, bus_d;
  logic [N_INPUTS-1:0] lvl;
  logic [N_INPUTS-1:0][5:0] sel_now;

  ////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < N_INPUTS; g++) begin : g_route
    pps_route u_route (
      .sel_in(sel_d.sel[g]),
      .pins_in(pins_in),
      .level_out(lvl[g])
    );
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input pps_sel_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < N_INPUTS; i++) begin
      if (a == PPS_SEL_BASE + 12'(4 * i)) begin
        r = {26'h0, s.sel[i]};
      end
    end
    return r;
  endfunction

  always_comb begin
    logic take;
    take = hsel && hready && htrans == PPS_HTRANS_NONSEQ;
    sel_d = sel_q;
    bus_d = bus_q;
    // Write data arrives one cycle after its address phase
    if (bus_q.wr_pend) begin
      for (int i = 0; i < N_INPUTS; i++) begin
        if (bus_q.addr == PPS_SEL_BASE + 12'(4 * i)) begin
          sel_d.sel[i] = hwdata[5:0];
        end
      end
    end
    bus_d.wr_pend = take && hwrite;
    bus_d.addr = haddr;
    bus_d.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      bus_d.rdata = read_word(haddr, sel_d);
    end
    bus_d.route = lvl;
  end

  ////////////////////////////////////////////////////////////////
  // Selectors live on the power-on domain only, so a bus reset keeps them; periph_out is cleared with the bus registers
  always_ff @(posedge clock_in or negedge por_rstn_in) begin
    if (!por_rstn_in) begin
      sel_q <= DEFAULTS;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_q <= '0;
    end else begin
      bus_q <= bus_d;
    end
  end

  assign sel_now = sel_q.sel;
  assign hrdata = bus_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = PPS_RESP_OKAY[0];
  assign periph_out = bus_q.route;

  ////////////////////////////////////////////////////////////////
  sequence wr_phase_s(int k);
    hsel && hready && htrans == PPS_HTRANS_NONSEQ && hwrite &&
      haddr == PPS_SEL_BASE + 12'(4 * k);
  endsequence

  sel_write_a: assert property (@(posedge clock_in) disable iff (!rstn_in || !por_rstn_in)
    wr_phase_s(0) ##1 1'b1 |=> sel_now[0] == $past(hwdata[5:0]))
    else $error("selector 0 did not take write data");
  upper_zero_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $past(hsel && htrans == PPS_HTRANS_NONSEQ && !hwrite, 1) |-> hrdata[31:6] == 26'h0)
    else $error("reserved read bits not zero");
  read_back_a: assert property (@(posedge clock_in) disable iff (!rstn_in || !por_rstn_in)
    hsel && htrans == PPS_HTRANS_NONSEQ && !hwrite && haddr == PPS_SEL_BASE
      && !bus_q.wr_pend |=> hrdata[5:0] == $past(sel_now[0]))
    else $error("selector read back wrong");
  // A write landing at this edge already steers the route, so it is excluded
  route_a: assert property (@(posedge clock_in) disable iff (!rstn_in || !por_rstn_in)
    !bus_q.wr_pend && $stable(sel_now[0]) && int'(sel_now[0][5:3]) < PPS_NUM_PORTS |=>
      periph_out[0] == $past(pins_in[sel_now[0]]))
    else $error("routed level wrong");
  bad_port_a: assert property (@(posedge clock_in) disable iff (!rstn_in || !por_rstn_in)
    !bus_q.wr_pend && $stable(sel_now[0]) && sel_now[0][5:4] == 2'b11 |=>
      periph_out[0] == 1'b0)
    else $error("reserved port not low");
  keep_sel_a: assert property (@(posedge clock_in) disable iff (!por_rstn_in)
    !rstn_in |=> $stable(sel_now[0]))
    else $error("selector changed under bus reset");
  no_wr_a: assert property (@(posedge clock_in) disable iff (!rstn_in || !por_rstn_in)
    !bus_q.wr_pend |=> $stable(sel_now))
    else $error("selector changed without write");
  por_load_a: assert property (@(posedge clock_in)
    !por_rstn_in |=> sel_now == DEFAULTS)
    else $error("selectors not loaded on power-on reset");
  ready_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule

// ===== tb/pps_pin_model.sv
`timescale 1ns/10ps
module pps_pin_model
  import pps_pkg::*;
(
  input wire logic [8*PPS_NUM_PORTS-1:0] level_in, // Wanted pin levels
  output logic [8*PPS_NUM_PORTS-1:0] pins_out // Port pins, port A lowest
);
  // Pins are plain inputs to the block, so levels pass straight through
  assign pins_out = level_in;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import pps_pkg::*;
;
  localparam logic [23:0] DEFS = 24'hBC4200;
  logic clock_in = 0, rstn_in = 0, por_rstn_in = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rd;
  logic hreadyout, hresp;
  logic [47:0] lv = '0, pins;
  logic [3:0] periph_out;
  int fails = 0, n_tests = 0;
  pps_pin_model pps_pin_model_inst (.level_in(lv), .pins_out(pins));
  pps_top #(.N_INPUTS(4), .DEFAULTS(DEFS)) pps_top_inst (.clock_in(clock_in),
    .rstn_in(rstn_in), .por_rstn_in(por_rstn_in), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins_in(pins),
    .periph_out(periph_out));
  initial forever #20 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Called just after a rising edge; waits on ready, never on a fixed count
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PPS_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic end_sim();
    $display("comparisons %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'b1;
    por_rstn_in <= 1'b1;
    @(posedge clock_in);
    for (int i = 0; i < 4; i++) begin
      bus(0, 12'(4 * i), '0);
      chk(rd, {26'h0, DEFS[6*i +: 6]}, "default");
    end
    lv <= 48'h1 << 47;
    repeat (3) @(posedge clock_in);
    chk(periph_out, 32'h8, "default routes");
    lv <= '0;
    $display("defaults done");
    bus(1, 12'h000, 32'hFFFFFFFF);
    bus(0, 12'h000, '0);
    chk(rd, 32'h0000003F, "upper bits");
    $display("access done");
    for (int p = 0; p < 6; p++) begin
      for (int n = 0; n < 8; n += 7 - p % 2) begin
        bus(1, 12'h000, {26'h0, 3'(p), 3'(n)});
        bus(0, 12'h000, '0);
        chk(rd, {26'h0, 3'(p), 3'(n)}, "sel rw");
        lv <= 48'h1 << (8 * p + n);
        repeat (3) @(posedge clock_in);
        chk(periph_out[0], 1'b1, "route high");
        lv <= ~(48'h1 << (8 * p + n));
        repeat (3) @(posedge clock_in);
        chk(periph_out[0], 1'b0, "route low");
      end
    end
    $display("routing done");
    bus(1, 12'h004, 32'h15);
    bus(1, 12'hF00, 32'h3F);
    bus(0, 12'hF00, '0);
    chk(rd, 32'h0, "unmapped");
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    bus(0, 12'h004, '0);
    chk(rd, 32'h15, "kept on bus reset");
    por_rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    por_rstn_in <= 1'b1;
    @(posedge clock_in);
    bus(0, 12'h004, '0);
    chk(rd, {26'h0, DEFS[11:6]}, "reload on power-on reset");
    $display("reset done");
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clock_in);
    fails++;
    end_sim();
  end
endmodule
